// [common/pcd_pkg.sv]
// package: constants and types for the pic command word decoder
// ============================================================
// Contract
// - cascade word taken only if single flag zero
// - master cascade bits mark attached slaves
// - master by pin, or buffered master flag
// - mode word only if follows flag set
// - family bit picks vector format
// - auto end flag ends service itself
// - buffered master flag only in buffered mode
// - buffered mode drives pin as enable
// - special nested flag selects special nesting
// - command words accepted any order after init
// - mask word writes and reads mask register
// - level field chooses one of eight levels
// - end bit triggers end of service
// - level enable applies level field
// - rotate bit triggers priority rotation
// - read command latches register read select
// - poll overrides register read
// - special mask changes only when enabled
// - first word clears service, mask, selects
// - words told apart by address, order, markers
package pcd_pkg;
    // ============================================================
    // word bit positions
    localparam int FIRST_MARK_BIT = 4;
    localparam int FIRST_FOLLOWS_BIT = 0;
    localparam int FIRST_SINGLE_BIT = 1;
    localparam int MODE_FAMILY_BIT = 0;
    localparam int MODE_AUTO_END_BIT = 1;
    localparam int MODE_MASTER_BIT = 2;
    localparam int MODE_BUFFERED_BIT = 3;
    localparam int MODE_NESTED_BIT = 4;
    localparam int CMD_MARK_BIT = 3;
    localparam int CMD_SELECT_BIT = 4;
    localparam int SER_END_BIT = 5;
    localparam int SER_LEVEL_EN_BIT = 6;
    localparam int SER_ROTATE_BIT = 7;
    localparam int RP_READ_SEL_BIT = 0;
    localparam int RP_READ_CMD_BIT = 1;
    localparam int RP_POLL_BIT = 2;
    localparam int RP_SPEC_MASK_BIT = 5;
    localparam int RP_SPEC_MASK_EN_BIT = 6;
    // ============================================================
    // reset values
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] CASCADE_RESET = 8'h00;
    localparam logic [2:0] LOWEST_RESET = 3'h7;
    // ============================================================
    // decoded service end / rotate commands
    typedef enum logic [2:0] {
        PCD_CMD_AUTO_ROT_CLR,
        PCD_CMD_NONSPEC_END,
        PCD_CMD_NOP,
        PCD_CMD_SPEC_END,
        PCD_CMD_AUTO_ROT_SET,
        PCD_CMD_ROT_NONSPEC_END,
        PCD_CMD_SET_PRIORITY,
        PCD_CMD_ROT_SPEC_END
    } pcd_cmd_t;
    // mode settings carried to the core
    typedef struct packed {
        logic family_16bit;
        logic auto_end;
        logic buffered;
        logic buffered_master;
        logic special_nested;
    } pcd_mode_t;
    // one service command event
    typedef struct packed {
        logic valid;
        pcd_cmd_t cmd;
        logic [2:0] level;
    } pcd_svc_t;
endpackage

// [core/pcd_decoder.sv]
// module: command word decoder of the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module pcd_decoder (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // host bus
    input wire logic cs_n_i,
    input wire logic wr_n_i,
    input wire logic rd_n_i,
    input wire logic word_select_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    // master select / buffer enable pin
    input wire logic msbe_i,
    output logic msbe_o,
    output logic msbe_oe_o,
    // core state inputs
    input wire logic [7:0] request_i,
    input wire logic [7:0] in_service_i,
    input wire logic [7:0] poll_word_i,
    // configuration outputs
    output var pcd_pkg::pcd_mode_t mode_o,
    output logic is_master_o,
    output logic [7:0] cascade_o,
    output logic [7:0] mask_o,
    output logic special_mask_o,
    output logic auto_rotate_o,
    output logic read_in_service_o,
    output logic init_done_o,
    output logic init_clear_o,
    // command events
    output var pcd_pkg::pcd_svc_t svc_o,
    output logic poll_o,
    output logic transceiver_en_i_unused_o
);
    // ============================================================
    // sequencer states and internal signals
    typedef enum logic [1:0] {
        PCD_ST_VECTOR, PCD_ST_CASCADE, PCD_ST_MODE, PCD_ST_READY
    } pcd_state_t;

    pcd_state_t state_r;
    logic cascade_wanted_r;
    logic mode_wanted_r;
    logic started_r;
    logic poll_read_r;
    pcd_pkg::pcd_mode_t mode_r;
    logic [7:0] cascade_r;
    logic [7:0] mask_r;
    logic special_mask_r;
    logic auto_rotate_r;
    logic read_sel_r;
    pcd_pkg::pcd_svc_t svc_r;
    logic poll_r;
    logic init_clear_r;
    logic [7:0] data_r;
    logic wr_r;
    logic wr_pulse;
    logic rd_now;
    logic first_word;
    logic mask_word;
    logic ser_word;
    logic rp_word;
    logic cascade_word;
    logic mode_word;

    // ============================================================
    // write strobe detection, one pulse per write cycle
    // a write held over several edges is taken only once
    assign rd_now = !cs_n_i && !rd_n_i;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_r <= 1'b0;
        end else begin
            wr_r <= !cs_n_i && !wr_n_i;
        end
    end
    assign wr_pulse = !cs_n_i && !wr_n_i && !wr_r;

    // ============================================================
    // word classification by address, sequence and marker bits
    // only one word kind is raised per write
    always_comb begin
        first_word = 1'b0;
        mask_word = 1'b0;
        ser_word = 1'b0;
        rp_word = 1'b0;
        cascade_word = 1'b0;
        mode_word = 1'b0;
        if (!wr_pulse) begin
            first_word = 1'b0;
        end else if (!word_select_i && data_i[pcd_pkg::FIRST_MARK_BIT]) begin
            first_word = 1'b1;
        end else if (word_select_i && state_r == PCD_ST_CASCADE) begin
            cascade_word = 1'b1;
        end else if (word_select_i && state_r == PCD_ST_MODE) begin
            mode_word = 1'b1;
        end else if (word_select_i && state_r == PCD_ST_READY) begin
            mask_word = 1'b1;
        end else if (!word_select_i && state_r == PCD_ST_READY) begin
            ser_word = !data_i[pcd_pkg::CMD_MARK_BIT];
            rp_word = data_i[pcd_pkg::CMD_MARK_BIT];
        end
    end

    // ============================================================
    // initialization sequencer
    // a first word restarts the sequence from any state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= PCD_ST_VECTOR;
            started_r <= 1'b0;
            cascade_wanted_r <= 1'b0;
            mode_wanted_r <= 1'b0;
        end else if (first_word) begin
            state_r <= PCD_ST_VECTOR;
            started_r <= 1'b1;
            cascade_wanted_r <= !data_i[pcd_pkg::FIRST_SINGLE_BIT];
            mode_wanted_r <= data_i[pcd_pkg::FIRST_FOLLOWS_BIT];
        end else if (wr_pulse && word_select_i && started_r) begin
            case (state_r)
                PCD_ST_VECTOR: begin
                    if (cascade_wanted_r) begin
                        state_r <= PCD_ST_CASCADE;
                    end else if (mode_wanted_r) begin
                        state_r <= PCD_ST_MODE;
                    end else begin
                        state_r <= PCD_ST_READY;
                    end
                end
                PCD_ST_CASCADE: begin
                    state_r <= mode_wanted_r ? PCD_ST_MODE : PCD_ST_READY;
                end
                PCD_ST_MODE: begin
                    state_r <= PCD_ST_READY;
                end
                default: begin
                    state_r <= PCD_ST_READY;
                end
            endcase
        end
    end

    // ============================================================
    // cascade word: slave map on master, identity on slave
    // the word is kept whole; the core reads the bits it needs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cascade_r <= pcd_pkg::CASCADE_RESET;
        end else if (cascade_word) begin
            cascade_r <= data_i;
        end
    end

    // ============================================================
    // mode word, cleared to defaults by the first word
    // without a mode word the pin keeps its select role
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_r <= '0;
        end else if (first_word) begin
            mode_r <= '0;
        end else if (mode_word) begin
            mode_r.family_16bit <= data_i[pcd_pkg::MODE_FAMILY_BIT];
            mode_r.auto_end <= data_i[pcd_pkg::MODE_AUTO_END_BIT];
            mode_r.buffered_master <= data_i[pcd_pkg::MODE_MASTER_BIT];
            mode_r.buffered <= data_i[pcd_pkg::MODE_BUFFERED_BIT];
            mode_r.special_nested <= data_i[pcd_pkg::MODE_NESTED_BIT];
        end
    end

    // ============================================================
    // mask register
    // a one bit masks the matching request input
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_r <= pcd_pkg::MASK_RESET;
        end else if (first_word) begin
            mask_r <= pcd_pkg::MASK_RESET;
        end else if (mask_word) begin
            mask_r <= data_i;
        end
    end

    // ============================================================
    // service end / rotate decode into one-cycle events
    // cmd and level only mean something while valid is high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            svc_r <= '0;
            auto_rotate_r <= 1'b0;
        end else begin
            svc_r.valid <= ser_word;
            svc_r.cmd <= pcd_pkg::pcd_cmd_t'({data_i[pcd_pkg::SER_ROTATE_BIT],
                data_i[pcd_pkg::SER_LEVEL_EN_BIT],
                data_i[pcd_pkg::SER_END_BIT]});
            svc_r.level <= data_i[2:0];
            if (first_word) begin
                auto_rotate_r <= 1'b0;
            end else if (ser_word && !data_i[pcd_pkg::SER_LEVEL_EN_BIT]
                && !data_i[pcd_pkg::SER_END_BIT]) begin
                auto_rotate_r <= data_i[pcd_pkg::SER_ROTATE_BIT];
            end
        end
    end

    // ============================================================
    // read, poll and special mask word
    // read select is latched even when a poll is asked for
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            read_sel_r <= 1'b0;
            special_mask_r <= 1'b0;
            poll_r <= 1'b0;
        end else begin
            poll_r <= rp_word && data_i[pcd_pkg::RP_POLL_BIT];
            if (first_word) begin
                read_sel_r <= 1'b0;
                special_mask_r <= 1'b0;
            end else if (rp_word) begin
                if (data_i[pcd_pkg::RP_READ_CMD_BIT]) begin
                    read_sel_r <= data_i[pcd_pkg::RP_READ_SEL_BIT];
                end
                if (data_i[pcd_pkg::RP_SPEC_MASK_EN_BIT]) begin
                    special_mask_r <= data_i[pcd_pkg::RP_SPEC_MASK_BIT];
                end
            end
        end
    end

    // ============================================================
    // poll answer replaces the next read once
    // cleared by the read that carries it, so it is used once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            poll_read_r <= 1'b0;
        end else if (rp_word) begin
            poll_read_r <= data_i[pcd_pkg::RP_POLL_BIT];
        end else if (rd_now) begin
            poll_read_r <= 1'b0;
        end
    end

    // ============================================================
    // read data register
    // a pending poll answer wins over mask and register select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_r <= 8'h00;
        end else if (poll_read_r) begin
            data_r <= poll_word_i;
        end else if (word_select_i) begin
            data_r <= mask_r;
        end else if (read_sel_r) begin
            data_r <= in_service_i;
        end else begin
            data_r <= request_i;
        end
    end

    // ============================================================
    // first word pulse toward the core
    // the core clears its in-service bits on this pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            init_clear_r <= 1'b0;
        end else begin
            init_clear_r <= first_word;
        end
    end

    // ============================================================
    // outputs
    assign data_o = data_r;
    assign data_oe_o = rd_now;
    assign msbe_oe_o = mode_r.buffered;
    // the enable is low during a host read and in the first cycle of a host write
    assign msbe_o = !(rd_now || wr_pulse) ? 1'b1 : 1'b0; // low enables
    assign is_master_o = mode_r.buffered ? mode_r.buffered_master : msbe_i;
    assign mode_o = mode_r;
    assign cascade_o = cascade_r;
    assign mask_o = mask_r;
    assign special_mask_o = special_mask_r;
    assign auto_rotate_o = auto_rotate_r;
    assign read_in_service_o = read_sel_r;
    assign init_done_o = state_r == PCD_ST_READY;
    assign init_clear_o = init_clear_r;
    assign svc_o = svc_r;
    assign poll_o = poll_r;
    // high-true transceiver enable in buffered mode during a read or the first cycle of a write
    assign transceiver_en_i_unused_o = mode_r.buffered
        && (rd_now || wr_pulse);
endmodule
`default_nettype wire

// [sim/pcd_decoder_chk.sv]
// checker: bus to output relations of the command word decoder
`timescale 1ns/100ps
`default_nettype none
module pcd_decoder_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // host bus
    input wire logic cs_n_i,
    input wire logic wr_n_i,
    input wire logic rd_n_i,
    input wire logic word_select_i,
    input wire logic [7:0] data_i,
    // pin and results
    input wire logic msbe_i,
    input wire logic msbe_o,
    input wire logic data_oe_o,
    input wire logic transceiver_en_i_unused_o,
    input wire logic msbe_oe_o,
    input wire pcd_pkg::pcd_mode_t mode_o,
    input wire logic is_master_o,
    input wire logic [7:0] mask_o,
    input wire logic special_mask_o,
    input wire logic read_in_service_o,
    input wire logic init_done_o,
    input wire logic init_clear_o,
    input wire pcd_pkg::pcd_svc_t svc_o,
    input wire logic poll_o
);
    // write strobes sorted by word kind
    logic wr_lo, wr_svc, wr_rp;
    assign wr_lo = !cs_n_i && !wr_n_i && !word_select_i;
    assign wr_svc = wr_lo && data_i[4:3] == 2'b00 && init_done_o;
    assign wr_rp = wr_lo && data_i[4:3] == 2'b01 && init_done_o;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ============================================================
    // properties
    property p_master;
        is_master_o == (mode_o.buffered ? mode_o.buffered_master : msbe_i);
    endproperty
    a_master: assert property (p_master)
        else $error("master select wrong");
    property p_pin;
        msbe_oe_o == mode_o.buffered;
    endproperty
    a_pin: assert property (p_pin)
        else $error("pin direction wrong");
    property p_svc;
        $past(wr_svc) |-> svc_o.valid &&
            {svc_o.cmd, svc_o.level} == $past({data_i[7:5], data_i[2:0]});
    endproperty
    a_svc: assert property (p_svc)
        else $error("service command wrong");
    property p_poll;
        poll_o == $past(wr_rp && data_i[2]);
    endproperty
    a_poll: assert property (p_poll)
        else $error("poll pulse wrong");
    property p_clear;
        $past(wr_lo && data_i[4]) |-> init_clear_o && mask_o == 8'h00 &&
            !special_mask_o && !read_in_service_o;
    endproperty
    a_clear: assert property (p_clear)
        else $error("first word clear wrong");
    property p_mask;
        $past(!cs_n_i && !wr_n_i && word_select_i && init_done_o)
            |-> mask_o == $past(data_i);
    endproperty
    a_mask: assert property (p_mask)
        else $error("mask load wrong");
    property p_smm;
        $past(wr_rp) |-> special_mask_o == ($past(data_i[6]) ?
            $past(data_i[5]) : $past(special_mask_o));
    endproperty
    a_smm: assert property (p_smm)
        else $error("special mask wrong");
    property p_ris;
        $past(wr_rp && data_i[1] && !data_i[2])
            |-> read_in_service_o == $past(data_i[0]);
    endproperty
    a_ris: assert property (p_ris)
        else $error("read select wrong");
    property p_oe;
        data_oe_o == (!cs_n_i && !rd_n_i) && (!data_oe_o || !msbe_o);
    endproperty
    a_oe: assert property (p_oe)
        else $error("read enable wrong");
    property p_xcvr;
        transceiver_en_i_unused_o == (msbe_oe_o && !msbe_o);
    endproperty
    a_xcvr: assert property (p_xcvr)
        else $error("transceiver enable wrong");
endmodule
bind pcd_decoder pcd_decoder_chk pcd_decoder_chk_i (.clk_i, .rst_i,
    .cs_n_i, .wr_n_i, .rd_n_i, .word_select_i, .data_i, .msbe_i, .msbe_o,
    .msbe_oe_o, .data_oe_o, .transceiver_en_i_unused_o, .mode_o,
    .is_master_o, .mask_o, .special_mask_o, .read_in_service_o,
    .init_done_o, .init_clear_o, .svc_o, .poll_o);
`default_nettype wire

// [sim/pcd_host_model.sv]
// host model: processor side of the decoder bus
`timescale 1ns/100ps
`default_nettype none
module pcd_host_model (
    // clock
    input wire logic clk_i,
    // bus toward the decoder
    output logic cs_n_o,
    output logic wr_n_o,
    output logic rd_n_o,
    output logic a0_o,
    output logic [7:0] dat_o,
    input wire logic [7:0] dat_i
);
    // idle bus at time zero
    initial begin
        {cs_n_o, wr_n_o, rd_n_o, a0_o} = 4'hE;
        dat_o = 8'h5A;
    end
    // one write cycle, released bus shows inverted data
    task automatic wr(input logic a, input logic [7:0] d);
        @(posedge clk_i);
        #2 {cs_n_o, wr_n_o, a0_o, dat_o} = {2'b00, a, d};
        @(posedge clk_i);
        #2 {cs_n_o, wr_n_o, dat_o} = {2'b11, ~d};
    endtask
    // one read cycle, data taken at the third edge, the second one with the read strobe low
    task automatic rd(input logic a, output logic [7:0] d);
        @(posedge clk_i);
        #2 {cs_n_o, rd_n_o, a0_o} = {2'b00, a};
        @(posedge clk_i);
        @(posedge clk_i);
        d = dat_i;
        #2 {cs_n_o, rd_n_o} = 2'b11;
    endtask
    // initialization sequence
    task automatic init(input logic f, s, input logic [7:0] c, m);
        wr(1'b0, {5'h02, 1'b0, s, f});
        wr(1'b1, 8'h40);
        if (!s) wr(1'b1, c);
        if (f) wr(1'b1, m);
    endtask
endmodule
`default_nettype wire

// [sim/pcd_decoder_tb_top.sv]
// testbench top for the command word decoder
`timescale 1ns/100ps
`default_nettype none
module pcd_decoder_tb_top;
    // ============================================================
    // signals
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cs_n_i, wr_n_i, rd_n_i, word_select_i, msbe_i, msbe_o, msbe_oe_o;
    logic strap, sm, read_select_bit, special_mask_o, read_in_service_o, init_done_o;
    logic poll_o, ar, mst, is_master_o, auto_rotate_o;
    logic [7:0] data_i, data_o, request_i, in_service_i, poll_word_i;
    logic [7:0] cascade_o, mask_o, c, m, d, got;
    pcd_pkg::pcd_mode_t mode_o;
    pcd_pkg::pcd_svc_t svc_o;
    int err_count = 0;
    int n_tests = 0;
    int seed = 3272;
    int op;
    always #12.5 clk_i = ~clk_i;
    assign msbe_i = msbe_oe_o ? msbe_o : strap;
    pcd_decoder pcd_decoder_i (.clk_i, .rst_i, .cs_n_i, .wr_n_i, .rd_n_i,
        .word_select_i, .data_i, .data_o, .data_oe_o(), .msbe_i, .msbe_o,
        .msbe_oe_o, .request_i, .in_service_i, .poll_word_i, .mode_o,
        .is_master_o, .cascade_o, .mask_o, .special_mask_o,
        .auto_rotate_o, .read_in_service_o, .init_done_o,
        .init_clear_o(), .svc_o, .poll_o, .transceiver_en_i_unused_o());
    pcd_host_model pcd_host_model_i (.clk_i, .cs_n_o(cs_n_i),
        .wr_n_o(wr_n_i), .rd_n_o(rd_n_i), .a0_o(word_select_i),
        .dat_o(data_i), .dat_i(data_o));
    // compare and closing
    task automatic chk(input logic [7:0] g, e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d of %0d checks", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    function automatic logic [7:0] exp_mode(input logic [7:0] w, input f);
        return f ? {3'h0, w[0], w[1], w[3], w[2], w[4]} : 8'h00;
    endfunction
    // eight random bits from the seeded stream
    function automatic logic [7:0] rnd8();
        int r;
        r = $random(seed);
        return r[7:0];
    endfunction
    // service word with given command bits
    task automatic svc_cmd(input logic [2:0] k);
        d = rnd8();
        pcd_host_model_i.wr(1'b0, {k, 2'b00, d[2:0]});
        if (k[1:0] == 2'b00) ar = k[2];
        chk({auto_rotate_o, svc_o}, {ar, 1'b1, k, d[2:0]});
    endtask
    // watchdog
    initial begin
        #500000;
        err_count++;
        print_verdict();
    end
    // main sequence
    initial begin
        {strap, request_i, in_service_i, poll_word_i} = 25'h1000000;
        repeat (3) @(posedge clk_i);
        #2 rst_i = 1'b0;
        pcd_host_model_i.wr(1'b1, 8'hA5);
        pcd_host_model_i.wr(1'b0, 8'h20);
        chk(mask_o, 8'h00);
        chk({7'h00, svc_o.valid}, 8'h00);
        for (int it = 0; it < 8; it++) begin
            d = rnd8();
            strap = d[0];
            m = rnd8();
            c = rnd8();
            mst = (it[0] && m[3]) ? m[2] : strap;
            if (!mst) begin
                c[7:3] = 5'h00;
                m[4] = 1'b0;
            end
            pcd_host_model_i.init(it[0], it[1], c, m);
            if (!it[1]) chk(cascade_o, c);
            chk({3'h0, mode_o}, exp_mode(m, it[0]));
            chk(mask_o, 8'h00);
            chk({7'h00, msbe_oe_o}, {7'h00, it[0] & m[3]});
            chk({7'h00, is_master_o}, {7'h00, mst});
            chk({6'h00, special_mask_o, read_in_service_o}, 8'h00);
            chk({7'h00, init_done_o}, 8'h01);
            {sm, read_select_bit, ar} = 3'b000;
            for (int k = 0; k < 8; k++) svc_cmd(k[2:0]);
            repeat (6) begin
                d = rnd8();
                op = $random(seed);
                if (op[1:0] == 2'd0) begin
                    pcd_host_model_i.wr(1'b1, d);
                    pcd_host_model_i.rd(1'b1, got);
                    chk(got, d);
                end else if (op[1:0] == 2'd1) svc_cmd(d[7:5]);
                else begin
                    d = (d & 8'h67) | 8'h08;
                    pcd_host_model_i.wr(1'b0, d);
                    if (d[6]) sm = d[5];
                    if (d[1]) read_select_bit = d[0];
                    chk({7'h00, special_mask_o}, {7'h00, sm});
                    chk({7'h00, poll_o}, {7'h00, d[2]});
                    op = $random(seed);
                    {request_i, in_service_i, poll_word_i} = op[23:0];
                    pcd_host_model_i.rd(1'b0, got);
                    chk(got, d[2] ? poll_word_i : read_select_bit ? in_service_i
                        : request_i);
                    if (d[2]) pcd_host_model_i.wr(1'b0, {7'h05, read_select_bit});
                    chk({7'h00, read_in_service_o}, {7'h00, read_select_bit});
                end
            end
        end
        print_verdict();
    end
endmodule
`default_nettype wire
